// ==== bench/reset_strap_peripheral_select_tb.sv ====
`timescale 1ns/1ps
module reset_strap_peripheral_select_tb;
   import rsps_pkg::*;
   logic        sys_clk, reset_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, boot_mode, boot_pins;
   logic [2:0]  hsize;
   logic [6:0]  level, upper_gpio_func;
   logic [7:0]  ex;
   logic        cell_pin, pci_pin, sp2_pin, autoinit_pin, end_pin, c, p, s, e;
   logic        sp1_en, cell_en, host_en, ug_en, pci_en, eep_en, sp2_en, init_req, aon, le;
   rsps_tris_t  pad_oe_n;
   int          errors = 0, n_tests = 0, cycles = 0, pulses;

   rsps_strap_board u_rsps_strap_board (.level(level), .cell_pin(cell_pin),
      .pci_pin(pci_pin), .sp2_pin(sp2_pin), .autoinit_pin(autoinit_pin), .end_pin(end_pin),
      .boot_pins(boot_pins));
   rsps_strap_select u_rsps_strap_select (.sys_clk(sys_clk), .reset_n(reset_n),
      .cell_select_strap_pin(cell_pin), .pci_select_pin(pci_pin),
      .serial_port2_enable(sp2_pin), .autoinit_strap_pin(autoinit_pin),
      .endian_strap_pin(end_pin), .boot_select_strap_pins(boot_pins), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .serial_port_one_en(sp1_en), .cell_port_en(cell_en), .host_port_en(host_en),
      .upper_gpio_en(ug_en), .pci_en(pci_en), .pci_eeprom_en(eep_en),
      .serial_port_two_en(sp2_en), .pci_autoinit_req(init_req), .always_on_en(aon),
      .little_endian(le), .boot_mode(boot_mode), .upper_gpio_func(upper_gpio_func),
      .pad_oe_n(pad_oe_n));

   // ==========
   // Clock, timeout and reporting
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Sixteen resets of a few dozen cycles each fit well inside this
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // ==========
   // AHB-Lite single word transfers
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'h1 && k < 50);
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      @(posedge sys_clk);
      hsel   <= 1'h1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= 3'h2;
      wait_rdy();
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      r = hrdata;
   endtask

   // ==========
   // Every combination of the cell, PCI, port-two and autoinit straps, each behind its own reset
   initial begin
      reset_n = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      level = 7'h40;
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         level   <= {2'(i % 3), i[0] ^ i[1], i[3], i[2], i[1], i[0]};
         reset_n <= 1'h0;
         repeat (4) @(posedge sys_clk);
         reset_n <= 1'h1;
         pulses = 0;
         repeat (5) begin
            @(posedge sys_clk);
            #1;
            pulses += int'(init_req === 1'h1);
         end
         {e, s, p, c} = level[3:0];
         ex = {1'h1, !(p & !s), p & !s, p, !p, !p, c, !c};
         chk(32'(pulses), 32'(p & !s & e));
         chk({aon, sp2_en, eep_en, pci_en, ug_en, host_en, cell_en, sp1_en}, ex);
         chk(pad_oe_n, {c, !c, p, !p});
         chk({le, boot_mode}, {level[4], level[6:5]});
         bus(1'h0, 32'(ADDR_STRAP), 32'h0, rd);
         chk(rd, {25'h0, level});
         bus(1'h0, 32'(ADDR_SELECT), 32'h0, rd);
         chk(rd, {23'h0, ex[7], 1'h0, ex[6:0]});
         bus(1'h1, 32'(ADDR_GPIO), 32'hA5A5_D6BC, rd);
         bus(1'h0, 32'(ADDR_GPIO), 32'h0, rd);
         chk(rd, 32'h0000_D6BC);
         chk(upper_gpio_func, p ? 7'h00 : 7'h14);
         bus(1'h0, 32'h0000_000C, 32'h0, rd);
         chk(rd, 32'h0);
         // Latched straps except PCI move, port-two enable is forced high live
         level <= (level ^ 7'h79) | 7'h04;
         repeat (6) @(posedge sys_clk);
         #1;
         chk({aon, sp2_en, eep_en, pci_en, ug_en, host_en, cell_en, sp1_en},
             {2'h3, 1'h0, ex[4:0]});
         chk({le, boot_mode, pad_oe_n}, {level[4] ^ 1'h1, level[6:5] ^ 2'h3, c, !c, p, !p});
         $display("test %0d done", i);
      end
      close_out();
   end
endmodule

// ==== bench/rsps_strap_board.sv ====
`timescale 1ns/1ps
// ==========
// Board straps: pull resistors plus the live port-two driver
module rsps_strap_board
   import rsps_pkg::*;
(
   // Levels {boot[1:0], endian, autoinit, port two, pci, cell}
   level,
   // Strap pins
   cell_pin,
   pci_pin,
   sp2_pin,
   autoinit_pin,
   end_pin,
   boot_pins
);
   input  wire logic [6:0] level;
   output logic            cell_pin;
   output logic            pci_pin;
   output logic            sp2_pin;
   output logic            autoinit_pin;
   output logic            end_pin;
   output logic      [1:0] boot_pins;
   // Every pin is always driven; pci only moves while reset is held
   assign {boot_pins, end_pin, autoinit_pin} = level[6:3];
   assign sp2_pin  = level[2];
   assign pci_pin  = level[1];
   assign cell_pin = level[0];
endmodule

// ==== rtl/rsps_pkg.sv ====
// Functional notes
// - Cell-port strap latched at reset selects port
// - Strap 0: serial port one, cell pins Hi-Z
// - Strap 1: cell port, serial-one pins Hi-Z
// - PCI strap latched at reset; port-two enable is not
// - PCI off: host port, upper GPIO usable
// - PCI off: PCI-only pins held Hi-Z
// - PCI on: host off, pins routed to PCI
// - Port two off only PCI=1, enable=0
// - That combination plus autoinit strap: EEPROM init
// - Port-two enable live; raising it drops EEPROM
// - Timers, port zero, lower GPIO always on
// - Other config from address and host straps
// - Endian strap 0 big, 1 little
// - Boot 00 none, 01 host, 10 ROM
// - Autoinit strap 0: PCI uses defaults
package rsps_pkg;
   // =====================================
   // Boot codes and AHB constants
   localparam logic [1:0] BOOT_NONE = 2'h0;
   localparam logic [1:0] BOOT_HOST = 2'h1;
   localparam logic [1:0] BOOT_ROM  = 2'h2;
   localparam logic [1:0] BOOT_RSVD = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   // =====================================
   // Register map
   localparam logic [7:0] ADDR_STRAP  = 8'h00;
   localparam logic [7:0] ADDR_SELECT = 8'h04;
   localparam logic [7:0] ADDR_GPIO   = 8'h08;
   // STRAP field positions
   localparam int S_CELL = 0;
   localparam int S_PCI  = 1;
   localparam int S_SP2  = 2;
   localparam int S_AUTOINIT = 3;
   localparam int S_LE   = 4;
   localparam int S_BOOT = 5;
   // SELECT field positions
   localparam int E_SP1   = 0;
   localparam int E_CELL  = 1;
   localparam int E_HOST  = 2;
   localparam int E_UGPIO = 3;
   localparam int E_PCI   = 4;
   localparam int E_EEP   = 5;
   localparam int E_SP2   = 6;
   localparam int E_INIT  = 7;
   localparam int E_ALWAYS = 8;
   localparam logic [15:0] GPIO_RESET = 16'h0000;

   typedef struct packed {
      logic [1:0] boot;
      logic       little_endian;
      logic       eeprom_autoinit;
      logic       pci_select;
      logic       cell_port_select;
   } rsps_straps_t;

   typedef struct packed {
      logic sp1_oe_n;
      logic cell_oe_n;
      logic host_oe_n;
      logic pci_only_oe_n;
   } rsps_tris_t;
endpackage

// ==== rtl/rsps_strap_select.sv ====
`timescale 1ns/1ps
module rsps_strap_select
   import rsps_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Strap pins
   input  wire logic        cell_select_strap_pin,
   input  wire logic        pci_select_pin,
   input  wire logic        serial_port2_enable,
   input  wire logic        autoinit_strap_pin,
   input  wire logic        endian_strap_pin,
   input  wire logic [1:0]  boot_select_strap_pins,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Peripheral enables
   output logic             serial_port_one_en,
   output logic             cell_port_en,
   output logic             host_port_en,
   output logic             upper_gpio_en,
   output logic             pci_en,
   output logic             pci_eeprom_en,
   output logic             serial_port_two_en,
   output logic             pci_autoinit_req,
   output logic             always_on_en,
   output logic             little_endian,
   output logic      [1:0]  boot_mode,
   output logic      [6:0]  upper_gpio_func,
   // Pad output enables, low while driving
   output rsps_tris_t       pad_oe_n
);
   // =====================================
   // Pin synchronisers
   logic [6:0]   sync1_reg;
   logic [6:0]   sync2_reg;
   logic [6:0]   pin_vec;
   assign pin_vec = {boot_select_strap_pins, endian_strap_pin, autoinit_strap_pin,
                     serial_port2_enable, pci_select_pin, cell_select_strap_pin};
   always_ff @(posedge sys_clk) begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
   end

   // =====================================
   // Strap capture on release; pins may still settle while reset is held
   logic          captured_reg;
   rsps_straps_t  straps_reg;
   logic          sp2_reg;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         captured_reg <= 1'b0;
         straps_reg   <= '0;
      end else if (!captured_reg) begin
         captured_reg <= 1'b1;
         straps_reg.cell_port_select <= sync2_reg[0];
         straps_reg.pci_select       <= sync2_reg[1];
         straps_reg.eeprom_autoinit  <= sync2_reg[3];
         straps_reg.little_endian    <= sync2_reg[4];
         straps_reg.boot             <= sync2_reg[6:5];
      end
   end
   // Port-two enable is followed all the time, not only at reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sp2_reg <= 1'b0;
      end else begin
         sp2_reg <= sync2_reg[2];
      end
   end

   // =====================================
   // Selection outputs; all idle until the straps are captured
   logic sp2_off;
   logic init_done_reg;
   assign sp2_off = straps_reg.pci_select && !sp2_reg;
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !captured_reg) begin
         serial_port_one_en <= 1'b0;
         cell_port_en       <= 1'b0;
         host_port_en       <= 1'b0;
         upper_gpio_en      <= 1'b0;
         pci_en             <= 1'b0;
         pci_eeprom_en      <= 1'b0;
         serial_port_two_en <= 1'b0;
         always_on_en       <= 1'b0;
         little_endian      <= 1'b0;
         boot_mode          <= BOOT_NONE;
         pad_oe_n           <= '1;
      end else begin
         serial_port_one_en <= !straps_reg.cell_port_select;
         cell_port_en       <= straps_reg.cell_port_select;
         pad_oe_n.sp1_oe_n  <= straps_reg.cell_port_select;
         pad_oe_n.cell_oe_n <= !straps_reg.cell_port_select;
         host_port_en       <= !straps_reg.pci_select;
         upper_gpio_en      <= !straps_reg.pci_select;
         pad_oe_n.host_oe_n <= straps_reg.pci_select;
         pad_oe_n.pci_only_oe_n <= !straps_reg.pci_select;
         pci_en             <= straps_reg.pci_select;
         pci_eeprom_en      <= sp2_off;
         serial_port_two_en <= !sp2_off;
         always_on_en       <= 1'b1;
         little_endian      <= straps_reg.little_endian;
         boot_mode          <= straps_reg.boot;
      end
   end

   // Auto-init request: one pulse after capture, only in the EEPROM combination
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         init_done_reg    <= 1'b0;
         pci_autoinit_req <= 1'b0;
      end else begin
         pci_autoinit_req <= 1'b0;
         if (captured_reg && !init_done_reg) begin
            init_done_reg <= 1'b1;
            // Autoinit strap low leaves PCI on built-in defaults
            pci_autoinit_req <= sp2_off && straps_reg.eeprom_autoinit;
         end
      end
   end

   // =====================================
   // AHB-Lite slave, zero wait states
   logic [15:0] gpio_cfg_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic        rd_phase;
   logic        wr_phase;
   assign rd_phase = hsel && hready && htrans[1] && !hwrite;
   assign wr_phase = hsel && hready && htrans[1] && hwrite;

   function automatic logic [31:0] read_mux(input logic [7:0] a);
      if (a == ADDR_STRAP) begin
         read_mux = {24'h000000, 1'b0, straps_reg.boot, straps_reg.little_endian,
                     straps_reg.eeprom_autoinit, sp2_reg, straps_reg.pci_select,
                     straps_reg.cell_port_select};
      end else if (a == ADDR_SELECT) begin
         read_mux = {23'h000000, always_on_en, pci_autoinit_req, serial_port_two_en,
                     pci_eeprom_en, pci_en, upper_gpio_en, host_port_en,
                     cell_port_en, serial_port_one_en};
      end else if (a == ADDR_GPIO) begin
         read_mux = {16'h0000, gpio_cfg_reg};
      end else begin
         read_mux = 32'h00000000;
      end
   endfunction

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         hrdata      <= 32'h00000000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= wr_phase;
         wr_addr_reg <= haddr[7:0];
         if (rd_phase) begin
            hrdata <= read_mux(haddr[7:0]);
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         gpio_cfg_reg <= GPIO_RESET;
      end else if (wr_pend_reg && wr_addr_reg == ADDR_GPIO) begin
         gpio_cfg_reg <= hwdata[15:0];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
   // Upper GPIO act only with enable bit set and PCI deselected
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         upper_gpio_func <= 7'h00;
      end else begin
         upper_gpio_func <= upper_gpio_en ? (gpio_cfg_reg[6:0] & gpio_cfg_reg[14:8])
                                          : 7'h00;
      end
   end

   // =====================================
   // Checks
   sequence s_cap;
      reset_n && captured_reg;
   endsequence
   AST_CELL_EXCL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_cap ##1 1'b1 |-> (cell_port_en != serial_port_one_en))
      else $error("cell and serial one not exclusive");
   AST_SP1_HIZ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cell_port_en |-> pad_oe_n.sp1_oe_n && !pad_oe_n.cell_oe_n)
      else $error("serial one pads not released");
   AST_CELL_HIZ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      serial_port_one_en |-> pad_oe_n.cell_oe_n)
      else $error("cell pads not released");
   AST_HOST_PCI: assert property (@(posedge sys_clk) disable iff (!reset_n)
      pci_en |-> !host_port_en && !upper_gpio_en && pad_oe_n.host_oe_n)
      else $error("host active with PCI");
   AST_PCI_HIZ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      host_port_en |-> pad_oe_n.pci_only_oe_n && !pci_en)
      else $error("PCI pins driven without PCI");
   AST_SP2: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_cap ##1 1'b1 |-> (serial_port_two_en == !(straps_reg.pci_select && !$past(sp2_reg))))
      else $error("port two enable wrong");
   AST_SP2_LIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_cap ##0 $rose(sp2_reg) ##1 1'b1 |-> serial_port_two_en && !pci_eeprom_en)
      else $error("raising enable did not drop EEPROM");
   AST_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_cap ##1 captured_reg |-> $stable(straps_reg))
      else $error("straps changed after capture");
   AST_INIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      pci_autoinit_req |-> pci_en && pci_eeprom_en && straps_reg.eeprom_autoinit)
      else $error("autoinit out of combination");

   // =====================================
   // Checks on the settled selection one cycle after capture, on idle outputs before it, and on the bus
   sequence s_live;
      s_cap ##1 1'b1;
   endsequence

   sequence s_eep;
      s_cap ##0 (straps_reg.pci_select && !sp2_reg);
   endsequence

   sequence s_gpio_wr;
      wr_phase && (haddr[7:0] == ADDR_GPIO) ##1 1'b1;
   endsequence

   AST_ALWAYS: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> always_on_en)
      else $error("always-on group not enabled");

   AST_ENDIAN: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> (little_endian == straps_reg.little_endian))
      else $error("endian output differs from strap");

   AST_BOOT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> (boot_mode == straps_reg.boot))
      else $error("boot mode differs from strap");

   AST_CELL_CAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> (cell_port_en == straps_reg.cell_port_select))
      else $error("cell port enable differs from strap");

   AST_HOST_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> (host_port_en == !straps_reg.pci_select) && (upper_gpio_en == host_port_en))
      else $error("host port enable differs from strap");

   AST_PCI_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> (pci_en == straps_reg.pci_select))
      else $error("PCI enable differs from strap");

   AST_SP2_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_eep |=> !serial_port_two_en && pci_eeprom_en)
      else $error("port two not disabled in EEPROM combination");

   AST_NO_INIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_cap ##0 !straps_reg.eeprom_autoinit |-> !pci_autoinit_req)
      else $error("autoinit requested with strap low");

   // Outputs must stay parked until capture, or pads would glitch at release
   AST_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !captured_reg ##1 1'b1 |-> (pad_oe_n == 4'hF) && !always_on_en)
      else $error("outputs active before capture");

   AST_UGPIO: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !upper_gpio_en ##1 1'b1 |-> (upper_gpio_func == 7'h00))
      else $error("upper GPIO active while deselected");

   AST_GPIO_WR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_gpio_wr |=> (gpio_cfg_reg == $past(hwdata[15:0])))
      else $error("GPIO configuration write lost");

   AST_STRAP_RD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rd_phase && (haddr[7:0] == ADDR_STRAP) |=> (hrdata[1:0] == $past({straps_reg.pci_select,
                                                  straps_reg.cell_port_select})))
      else $error("strap readback wrong");

   AST_PAD_SP1: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live ##0 straps_reg.cell_port_select |-> pad_oe_n.sp1_oe_n && cell_port_en)
      else $error("serial one pads driven with cell port");

   // Zero wait state slave; a stall here would hang every master
   AST_OKAY: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_live |-> hreadyout && !hresp)
      else $error("bus not ready or error response");
endmodule
